// File: dbs_pkg.sv
// Package for the data buffer steering block: constants and carrier types.
// Assumes a single 10 MHz reference clock; the only software-visible registers are the two read-only latch slots.
`default_nettype none

package dbs_pkg;

  // Bus widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 10;
  localparam int HALF_W = 16;

  // Reset values
  localparam logic RST_DIR       = 1'b1; // Write direction is the resting level
  localparam logic RST_OE        = 1'b0;
  localparam logic [31:0] RST_DATA = 32'h0000_0000;
  localparam logic [1:0] RST_STEER = 2'h0;  // Processor to memory-bus DRAM
  localparam logic       RST_OWNER = 1'b1;  // Processor owns the bus
  localparam logic [9:0] RST_ADDR  = 10'h000;

  // Internal register slots decoded from the peripheral address
  localparam logic [9:0] LATCH_LO_ADDR = 10'h0e0;
  localparam logic [9:0] LATCH_HI_ADDR = 10'h0e2;

  // Steering choices
  typedef enum logic [1:0] {
    DBS_STEER_CPU_MEM,
    DBS_STEER_CPU_LOCAL,
    DBS_STEER_OWNER_MEM,
    DBS_STEER_OWNER_UPPER
  } dbs_steer_t;

  // Synchronised control inputs
  typedef struct packed {
    logic xbusEnableN;
    logic intAckN;
    logic narrowTranslate;
    logic holdAck;
    logic placementStrap;
    logic busOwnerN;
    logic videoCmdN;
    logic ioReadN;
    logic progDecode;
  } dbs_ctrl_t;

endpackage

`default_nettype wire

// File: data_buffer_steering.sv
// Data buffer steering control: transceiver direction, local bus drive and read latch.
// Assumes all control pins are asynchronous to ref_clk and are synchronised here.
`timescale 1ns/10ps
`default_nettype none

module data_buffer_steering (
  input  wire logic                        ref_clk,
  input  wire logic                        resetn,
  input  wire logic                        system_reset_in,
  input  wire logic                        xbus_xcvr_enable_n,
  input  wire logic                        int_ack_n,
  input  wire logic                        narrow_owner_translate,
  input  wire logic                        hold_ack,
  input  wire logic                        dram_placement_strap,
  input  wire logic                        bus_owner_n,
  input  wire logic                        video_cmd_strobe_n,
  input  wire logic                        periph_io_read_n,
  input  wire logic                        prog_decode_out,
  input  wire logic [dbs_pkg::ADDR_W-1:0]  periph_addr,
  input  wire logic [dbs_pkg::DATA_W-1:0]  mem_data_in,
  input  wire logic [dbs_pkg::DATA_W-1:0]  cpu_local_data_in,
  output logic      [dbs_pkg::DATA_W-1:0]  cpu_local_data_out,
  output logic                             cpu_local_data_oe,
  output logic                             xbus_direction,
  output logic      [1:0]                  steer_select,
  output logic                             owner_is_cpu
);

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the control, address, memory data and system reset inputs
  dbs_pkg::dbs_ctrl_t ctrlMeta_reg;
  dbs_pkg::dbs_ctrl_t ctrlSync_reg;
  logic [dbs_pkg::ADDR_W-1:0] addrMeta_reg;
  logic [dbs_pkg::ADDR_W-1:0] addrSync_reg;
  logic [dbs_pkg::DATA_W-1:0] memMeta_reg;
  logic [dbs_pkg::DATA_W-1:0] memSync_reg;
  logic                       rstMeta_reg;
  logic                       rstSync_reg;
  dbs_pkg::dbs_ctrl_t ctrlRaw;

  // Gather raw control pins
  always_comb begin
    ctrlRaw.xbusEnableN     = xbus_xcvr_enable_n;
    ctrlRaw.intAckN         = int_ack_n;
    ctrlRaw.narrowTranslate = narrow_owner_translate;
    ctrlRaw.holdAck         = hold_ack;
    ctrlRaw.placementStrap  = dram_placement_strap;
    ctrlRaw.busOwnerN       = bus_owner_n;
    ctrlRaw.videoCmdN       = video_cmd_strobe_n;
    ctrlRaw.ioReadN         = periph_io_read_n;
    ctrlRaw.progDecode      = prog_decode_out;
  end

  // Synchroniser flops; idle levels after reset, except the system reset pair, which loads asserted
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrlMeta_reg <= '{xbusEnableN: 1'b1, intAckN: 1'b1, busOwnerN: 1'b1, videoCmdN: 1'b1, ioReadN: 1'b1,
                        default: 1'b0};
      ctrlSync_reg <= '{xbusEnableN: 1'b1, intAckN: 1'b1, busOwnerN: 1'b1, videoCmdN: 1'b1, ioReadN: 1'b1,
                        default: 1'b0};
      addrMeta_reg <= dbs_pkg::RST_ADDR;
      addrSync_reg <= dbs_pkg::RST_ADDR;
      memMeta_reg  <= dbs_pkg::RST_DATA;
      memSync_reg  <= dbs_pkg::RST_DATA;
      rstMeta_reg  <= 1'b1;
      rstSync_reg  <= 1'b1;
    end else begin
      ctrlMeta_reg <= ctrlRaw;
      ctrlSync_reg <= ctrlMeta_reg;
      addrMeta_reg <= periph_addr;
      addrSync_reg <= addrMeta_reg;
      memMeta_reg  <= mem_data_in;
      memSync_reg  <= memMeta_reg;
      rstMeta_reg  <= system_reset_in;
      rstSync_reg  <= rstMeta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic isLatchAddr(input logic [dbs_pkg::ADDR_W-1:0] a);
    isLatchAddr = (a == dbs_pkg::LATCH_LO_ADDR) || (a == dbs_pkg::LATCH_HI_ADDR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Steering, direction, latch and drive next-state
  logic                       xbusDirection_reg;
  logic                       xbusDirection_next;
  logic [1:0]                 steer_reg;
  logic [1:0]                 steer_next;
  logic                       ownerCpu_reg;
  logic                       ownerCpu_next;
  logic [dbs_pkg::DATA_W-1:0] readLatch_reg;
  logic [dbs_pkg::DATA_W-1:0] readLatch_next;
  logic [dbs_pkg::DATA_W-1:0] dataOut_reg;
  logic [dbs_pkg::DATA_W-1:0] dataOut_next;
  logic                       dataOe_reg;
  logic                       dataOe_next;
  logic                       periphRead;
  logic                       regHit;
  dbs_pkg::dbs_steer_t        steerSel;

  always_comb begin
    // Peripheral read in progress: enable low and read strobe low, not a programmable decode
    periphRead = !ctrlSync_reg.xbusEnableN && !ctrlSync_reg.ioReadN
                 && !ctrlSync_reg.progDecode;
    // Read when a peripheral read or interrupt acknowledge, else rest high
    xbusDirection_next = !(periphRead || !ctrlSync_reg.intAckN);
    // Non-processor owner: hold acknowledge or external owner present
    ownerCpu_next = !(ctrlSync_reg.holdAck || !ctrlSync_reg.busOwnerN);
    if (!ownerCpu_next && ctrlSync_reg.narrowTranslate) begin
      steerSel = dbs_pkg::DBS_STEER_OWNER_UPPER;
    end else if (!ownerCpu_next) begin
      steerSel = ctrlSync_reg.placementStrap ? dbs_pkg::DBS_STEER_CPU_LOCAL
                                             : dbs_pkg::DBS_STEER_OWNER_MEM;
    end else begin
      steerSel = ctrlSync_reg.placementStrap ? dbs_pkg::DBS_STEER_CPU_LOCAL
                                             : dbs_pkg::DBS_STEER_CPU_MEM;
    end
    steer_next = steerSel;
    // Video command captures memory data into the read latches
    readLatch_next = !ctrlSync_reg.videoCmdN ? memSync_reg : readLatch_reg;
    // Register read of the latch slots drives the local bus while the processor owns it
    regHit = isLatchAddr(addrSync_reg) && !ctrlSync_reg.ioReadN;
    dataOe_next = regHit && ownerCpu_next;
    if (regHit && steerSel == dbs_pkg::DBS_STEER_OWNER_UPPER) begin
      dataOut_next = {readLatch_reg[dbs_pkg::HALF_W-1:0], readLatch_reg[dbs_pkg::DATA_W-1:dbs_pkg::HALF_W]};
    end else if (regHit && addrSync_reg == dbs_pkg::LATCH_HI_ADDR) begin
      dataOut_next = {16'h0000, readLatch_reg[dbs_pkg::DATA_W-1:dbs_pkg::HALF_W]};
    end else if (regHit) begin
      dataOut_next = readLatch_reg;
    end else begin
      dataOut_next = dbs_pkg::RST_DATA;
    end
    // System reset forces every state to its default
    if (rstSync_reg) begin
      xbusDirection_next = dbs_pkg::RST_DIR;
      ownerCpu_next      = dbs_pkg::RST_OWNER;
      steer_next         = dbs_pkg::RST_STEER;
      readLatch_next     = dbs_pkg::RST_DATA;
      dataOut_next       = dbs_pkg::RST_DATA;
      dataOe_next        = dbs_pkg::RST_OE;
    end
  end

  // State registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      xbusDirection_reg <= dbs_pkg::RST_DIR;
      steer_reg         <= dbs_pkg::RST_STEER;
      ownerCpu_reg      <= dbs_pkg::RST_OWNER;
      readLatch_reg     <= dbs_pkg::RST_DATA;
      dataOut_reg       <= dbs_pkg::RST_DATA;
      dataOe_reg        <= dbs_pkg::RST_OE;
    end else begin
      xbusDirection_reg <= xbusDirection_next;
      steer_reg         <= steer_next;
      ownerCpu_reg      <= ownerCpu_next;
      readLatch_reg     <= readLatch_next;
      dataOut_reg       <= dataOut_next;
      dataOe_reg        <= dataOe_next;
    end
  end

  // Outputs straight from flops
  assign xbus_direction     = xbusDirection_reg;
  assign steer_select       = steer_reg;
  assign owner_is_cpu       = ownerCpu_reg;
  assign cpu_local_data_out = dataOut_reg;
  assign cpu_local_data_oe  = dataOe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_dir_read_ack: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!ctrlSync_reg.intAckN && !rstSync_reg) |=> !xbus_direction) else $error("ack did not force read");
  a_dir_rest_high: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ctrlSync_reg.intAckN && (ctrlSync_reg.xbusEnableN || ctrlSync_reg.ioReadN)) |=> xbus_direction)
    else $error("direction left rest");
  a_dir_periph_rd: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!ctrlSync_reg.xbusEnableN && !ctrlSync_reg.ioReadN && !ctrlSync_reg.progDecode && !rstSync_reg)
    |=> !xbus_direction) else $error("peripheral read not low");
  a_dir_prog_skip: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ctrlSync_reg.progDecode && ctrlSync_reg.intAckN) |=> xbus_direction)
    else $error("decode switched dir");
  a_reset_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    rstSync_reg |=> (xbus_direction && !cpu_local_data_oe && owner_is_cpu)) else $error("reset not idle");
  a_owner_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ctrlSync_reg.holdAck && !rstSync_reg) |=> !owner_is_cpu) else $error("hold not owner");
  a_owner_ext: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!ctrlSync_reg.busOwnerN && !rstSync_reg) |=> (!owner_is_cpu && !cpu_local_data_oe))
    else $error("ext owner ignored");
  a_steer_upper: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ctrlSync_reg.holdAck && ctrlSync_reg.narrowTranslate && !rstSync_reg) |=> steer_select == 2'b11)
    else $error("narrow not upper");
  a_steer_strap: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ctrlSync_reg.placementStrap && !ctrlSync_reg.narrowTranslate && !rstSync_reg) |=> steer_select == 2'b01)
    else $error("strap not local");
  a_latch_video: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!ctrlSync_reg.videoCmdN && !rstSync_reg) |=> readLatch_reg == $past(memSync_reg))
    else $error("latch missed");
  a_drive_read: assert property (@(posedge ref_clk) disable iff (!resetn)
    (isLatchAddr(addrSync_reg) && !ctrlSync_reg.ioReadN && ownerCpu_next && !rstSync_reg) |=> cpu_local_data_oe)
    else $error("no local drive");

  c_periph_read: cover property (@(posedge ref_clk) disable iff (!resetn) $fell(xbus_direction));
  c_int_ack: cover property (@(posedge ref_clk) disable iff (!resetn) !ctrlSync_reg.intAckN ##1 !xbus_direction);
  c_narrow: cover property (@(posedge ref_clk) disable iff (!resetn) steer_select == 2'b11);
  c_reg_read: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(cpu_local_data_oe));

endmodule

`default_nettype wire

// File: dbs_mem_model.sv
// Partner model of the memory controller: video strobe, transceiver enable, memory data.
// Assumes requests from the bench; pins change only at ref_clk rising edges.
`timescale 1ns/10ps
`default_nettype none

module dbs_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        videoReq,
  input  wire logic        xbusReq,
  input  wire logic [31:0] wordIn,
  output var  logic        video_cmd_strobe_n,
  output var  logic        xbus_xcvr_enable_n,
  output var  logic [31:0] mem_data_in
);
  initial begin
    video_cmd_strobe_n = 1'b1;
    xbus_xcvr_enable_n = 1'b1;
    mem_data_in        = 32'h0000_0000;
  end

  // Strobes follow requests; released data bus flips every cycle, never holds
  always @(posedge ref_clk) begin
    video_cmd_strobe_n <= !videoReq;
    xbus_xcvr_enable_n <= !xbusReq;
    mem_data_in        <= videoReq ? wordIn : ~mem_data_in;
  end
endmodule

`default_nettype wire

// File: data_buffer_steering_tb.sv
// Self-checking bench for the data buffer steering block.
// Assumes the three-edge input-to-output lag of the design.
`timescale 1ns/10ps
`default_nettype none

module data_buffer_steering_tb;
  logic ref_clk = 1'b0, resetn = 1'b0, sysRst = 1'b0, intAckN = 1'b1, narrow = 1'b0;
  logic holdAck = 1'b0, strap = 1'b0, ownerN = 1'b1, ioRdN = 1'b1, prog = 1'b0;
  logic videoReq = 1'b0, xbusReq = 1'b0, videoN, xdenN, ldOe, dir, ownCpu;
  logic [9:0]  addr = 10'h000;
  logic [31:0] word = 32'hc3a5_5a3c, memData, ldOut;
  logic [1:0]  steer;
  int          numErrors = 0, nTests = 0;

  always #50 ref_clk = ~ref_clk;

  dbs_mem_model mem_u (.ref_clk(ref_clk), .videoReq(videoReq), .xbusReq(xbusReq), .wordIn(word),
    .video_cmd_strobe_n(videoN), .xbus_xcvr_enable_n(xdenN), .mem_data_in(memData));

  data_buffer_steering dut_u (.ref_clk(ref_clk), .resetn(resetn), .system_reset_in(sysRst),
    .xbus_xcvr_enable_n(xdenN), .int_ack_n(intAckN), .narrow_owner_translate(narrow),
    .hold_ack(holdAck), .dram_placement_strap(strap), .bus_owner_n(ownerN),
    .video_cmd_strobe_n(videoN), .periph_io_read_n(ioRdN), .prog_decode_out(prog),
    .periph_addr(addr), .mem_data_in(memData), .cpu_local_data_in(~word),
    .cpu_local_data_out(ldOut), .cpu_local_data_oe(ldOe), .xbus_direction(dir),
    .steer_select(steer), .owner_is_cpu(ownCpu));

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic settle;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      numErrors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chk_defaults;
    chk("dir", {31'h0, dir}, {31'h0, dbs_pkg::RST_DIR});
    chk("oe", {31'h0, ldOe}, {31'h0, dbs_pkg::RST_OE});
    chk("data", ldOut, dbs_pkg::RST_DATA);
    chk("steer", {30'h0, steer}, {30'h0, dbs_pkg::RST_STEER});
    chk("owner", {31'h0, ownCpu}, {31'h0, dbs_pkg::RST_OWNER});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_dir;
    settle;
    chk("dir idle", {31'h0, dir}, 32'h1);
    @(posedge ref_clk) intAckN <= 1'b0;
    settle;
    chk("dir int_ack_n", {31'h0, dir}, 32'h0);
    @(posedge ref_clk) begin
      intAckN <= 1'b1;
      xbusReq <= 1'b1;
      ioRdN   <= 1'b0;
    end
    settle;
    chk("dir read", {31'h0, dir}, 32'h0);
    @(posedge ref_clk) prog <= 1'b1;
    settle;
    chk("dir prog", {31'h0, dir}, 32'h1);
    @(posedge ref_clk) begin
      prog    <= 1'b0;
      xbusReq <= 1'b0;
    end
    settle;
    chk("dir noen", {31'h0, dir}, 32'h1);
    @(posedge ref_clk) ioRdN <= 1'b1;
  endtask

  task automatic t_latch;
    @(posedge ref_clk) videoReq <= 1'b1;
    settle;
    @(posedge ref_clk) videoReq <= 1'b0;
    settle;
    @(posedge ref_clk) begin addr <= dbs_pkg::LATCH_LO_ADDR; ioRdN <= 1'b0; end
    settle;
    chk("oe rd", {31'h0, ldOe}, 32'h1);
    chk("latch lo", ldOut, word);
    @(posedge ref_clk) addr <= dbs_pkg::LATCH_HI_ADDR;
    settle;
    chk("latch hi", ldOut, {16'h0000, word[31:16]});
    // Narrow owner reading the latch: halves swapped, local bus not driven
    @(posedge ref_clk) begin
      holdAck <= 1'b1;
      narrow  <= 1'b1;
    end
    settle;
    chk("latch swap", ldOut, {word[15:0], word[31:16]});
    chk("oe owner", {31'h0, ldOe}, 32'h0);
    @(posedge ref_clk) begin
      holdAck <= 1'b0;
      narrow  <= 1'b0;
      ioRdN   <= 1'b1;
    end
    settle;
    chk("oe idle", {31'h0, ldOe}, 32'h0);
    chk("data idle", ldOut, dbs_pkg::RST_DATA);
  endtask

  // Columns: hold, external owner, strap, narrow, expected steering
  task automatic t_steer;
    logic [5:0] tbl [7];
    tbl = '{6'b000000, 6'b001001, 6'b100010, 6'b010010, 6'b101001, 6'b100111, 6'b011111};
    foreach (tbl[i]) begin
      @(posedge ref_clk) begin
        holdAck <= tbl[i][5];
        ownerN  <= !tbl[i][4];
        strap   <= tbl[i][3];
        narrow  <= tbl[i][2];
      end
      settle;
      chk("steer", {30'h0, steer}, {30'h0, tbl[i][1:0]});
      chk("owner", {31'h0, ownCpu}, {31'h0, !(tbl[i][5] | tbl[i][4])});
    end
  endtask

  task automatic t_sysrst;
    @(posedge ref_clk) begin sysRst <= 1'b1; intAckN <= 1'b0; end
    settle;
    chk_defaults;
    @(posedge ref_clk) begin sysRst <= 1'b0; intAckN <= 1'b1; holdAck <= 1'b0; ownerN <= 1'b1; end
    @(posedge ref_clk) begin strap <= 1'b0; narrow <= 1'b0; end
    settle;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, watchdog and main sequence
  task automatic endSim;
    if (numErrors == 0 && nTests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog: the scenarios need about 130 cycles, so 2000 means a hang
  initial begin
    repeat (2000) @(posedge ref_clk);
    numErrors++;
    endSim;
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    chk_defaults;
    @(posedge ref_clk) resetn <= 1'b1;
    t_dir;
    t_latch;
    t_steer;
    t_sysrst;
    endSim;
  end
endmodule

`default_nettype wire
